// File: src/fwsr_params.svh
// Constants for the flash status poll controller.
// Assumes a 100 MHz mclk; included by bare name.
`ifndef FWSR_PARAMS_SVH
`define FWSR_PARAMS_SVH
// ****************************************************
// Register offsets (APB byte addresses)
// ****************************************************
`define FWSR_CTRL_OFF      12'h000
`define FWSR_ADDR_OFF      12'h004
`define FWSR_DATA_OFF      12'h008
`define FWSR_STAT_OFF      12'h00C
`define FWSR_RDAT_OFF      12'h010
// ****************************************************
// Field positions
// ****************************************************
`define FWSR_CTRL_GO       0
`define FWSR_CTRL_OP_LO    1
`define FWSR_STAT_BUSY     0
`define FWSR_STAT_DONE     1
`define FWSR_STAT_FAIL     2
`define FWSR_STAT_WIN      3
`define FWSR_STAT_RST      4
`define FWSR_POLL_BIT      7
`define FWSR_TOG_BIT       6
`define FWSR_FAIL_BIT      5
`define FWSR_WIN_BIT       3
`define FWSR_ESTOG_BIT     2
// ****************************************************
// Timing
// ****************************************************
`define FWSR_CLK_NS        10
`define FWSR_RST_LOW_NS    500
`define FWSR_RST_RDY_NS    20000
`define FWSR_RST_LOW_CYC   ((`FWSR_RST_LOW_NS + `FWSR_CLK_NS - 1) / `FWSR_CLK_NS)
`define FWSR_RST_RDY_CYC   ((`FWSR_RST_RDY_NS + `FWSR_CLK_NS - 1) / `FWSR_CLK_NS)
`define FWSR_STROBE_CYC    8
`endif

// File: src/fwsr_pkg.sv
// Types for the flash status poll controller.
// Assumes fwsr_params.svh is included ahead of users.
package fwsr_pkg;
    // Operations software can order
    typedef enum logic [2:0] {
        FWSR_OP_READ,
        FWSR_OP_WRITE,
        FWSR_OP_POLL,
        FWSR_OP_TOGGLE,
        FWSR_OP_RESET
    } fwsr_op_type;
    // Controller states
    typedef enum logic [3:0] {
        FWSR_IDLE,
        FWSR_RD1,
        FWSR_RD2,
        FWSR_WR,
        FWSR_EVAL,
        FWSR_RST_LOW,
        FWSR_RST_WAIT
    } fwsr_state_type;
endpackage

// File: src/fwsr_if.sv
// Bus cycle request between controller and pin strobe engine.
// Assumes one mclk domain.
`timescale 1ns/10ps
interface fwsr_if;
    logic       req;
    logic       wr;
    logic [17:0] addr;
    logic [7:0] wdata;
    logic       ack;
    logic [7:0] rdata;
    modport ctl (output req, output wr, output addr, output wdata,
                 input ack, input rdata);
    modport eng (input req, input wr, input addr, input wdata,
                 output ack, output rdata);
endinterface

// File: src/fwsr_strobe.sv
// Pin strobe engine: one flash read or write cycle per request.
// Assumes flash pins synchronous to mclk; data bus split in/out/oe.
`timescale 1ns/10ps
`include "fwsr_params.svh"
module fwsr_strobe
    import fwsr_pkg::*;
#(
    parameter int STROBE_CYC = `FWSR_STROBE_CYC
) (
    // Clock and reset
    input  wire logic  mclk,
    input  wire logic  reset_n,
    // Request side
    fwsr_if.eng        bus,
    // Flash pins
    output logic       ce_n,
    output logic       oe_n,
    output logic       we_n,
    output logic [17:0] fa,
    output logic [7:0] fd_out,
    output logic       fd_oe_n,
    input  wire logic [7:0] fd_in
);
    // Refuse strobe lengths under 2 or beyond what the 8-bit counter holds
    if (STROBE_CYC < 2 || STROBE_CYC > 255) begin : g_bad_strobe
        $error("STROBE_CYC out of range");
    end
    logic [7:0] cnt_r;
    logic       act_r;
    logic       ack_r;
    logic [7:0] rdata_r;
    assign bus.ack   = ack_r;
    assign bus.rdata = rdata_r;
    // Strobe sequencer: assert strobes, count, sample at end, rise
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            act_r   <= 1'b0;
            cnt_r   <= 8'h00;
            ack_r   <= 1'b0;
            rdata_r <= 8'h00;
            ce_n    <= 1'b1;
            oe_n    <= 1'b1;
            we_n    <= 1'b1;
            fa      <= 18'h0_0000;
            fd_out  <= 8'h00;
            fd_oe_n <= 1'b1;
        end else begin
            ack_r <= 1'b0;
            if (!act_r && bus.req && !ack_r) begin
                act_r   <= 1'b1;
                cnt_r   <= 8'(STROBE_CYC);
                fa      <= bus.addr;
                fd_out  <= bus.wdata;
                fd_oe_n <= !bus.wr;
                ce_n    <= 1'b0;
                oe_n    <= bus.wr;
                we_n    <= !bus.wr;
            end else if (act_r) begin
                if (cnt_r == 8'h01) begin
                    act_r   <= 1'b0;
                    ack_r   <= 1'b1;
                    rdata_r <= fd_in;
                    ce_n    <= 1'b1;
                    oe_n    <= 1'b1;
                    we_n    <= 1'b1;
                    fd_oe_n <= 1'b1;
                end else begin
                    cnt_r <= cnt_r - 8'h01;
                end
            end
        end
    end
endmodule

// File: src/fwsr_ctrl.sv
// Flash write status poll controller with APB register slave.
// Assumes the flash pins are synchronous to mclk; APB from software.
// ****************************************************
// Operation
// (R1) Program poll: bit 7 complement while busy
// (R2) Status valid after final command write
// (R3) Erase poll: bit 7 zero until done
// (R4) Poll address inside target sector
// (R5) Re-read after poll success for data
// (R6) Busy bit toggles each read while busy
// (R7) Toggle also in window and suspend
// (R8) Protected program toggles briefly, no change
// (R9) Protected erase toggles longer, no change
// (R10) Fail bit set on pulse limit
// (R11) Program 1 over 0 locks, fails
// (R12) On fail, host resets the device
// (R13) Window bit zero during acceptance time-out
// (R14) Window zero accepts more sector erases
// (R15) Check window bit before and after
// (R16) Erase toggle only in erasing sectors
// (R17) On fail, erase toggle marks bad sector
// (R18) Suspended sector: poll 1, busy steady
// (R19) Hold reset low at least 500 ns
// (R20) Reset aborts; ready after 20 us
// (R21) Outputs tri-state while reset low
// (R22) Power-up read mode; sequences change memory
// ****************************************************
`timescale 1ns/10ps
`include "fwsr_params.svh"
module fwsr_ctrl
    import fwsr_pkg::*;
#(
    parameter int RST_RDY_CYC = `FWSR_RST_RDY_CYC,
    parameter int STROBE_CYC  = `FWSR_STROBE_CYC
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        reset_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Flash pins
    output logic             ce_n,
    output logic             oe_n,
    output logic             we_n,
    output logic             frst_n,
    output logic [17:0]      fa,
    output logic [7:0]       fd_out,
    output logic             fd_oe_n,
    input  wire logic [7:0]  fd_in
);
    localparam int RST_LOW_CYC = `FWSR_RST_LOW_CYC;
    // Refuse ready times shorter than the pulse or beyond the counter
    if (RST_RDY_CYC < RST_LOW_CYC || RST_RDY_CYC > 65535) begin : g_bad_rdy
        $error("RST_RDY_CYC out of range");
    end
    fwsr_if bus ();
    fwsr_strobe #(.STROBE_CYC(STROBE_CYC)) u_strobe (
        .mclk    (mclk),
        .reset_n (reset_n),
        .bus     (bus),
        .ce_n    (ce_n),
        .oe_n    (oe_n),
        .we_n    (we_n),
        .fa      (fa),
        .fd_out  (fd_out),
        .fd_oe_n (fd_oe_n),
        .fd_in   (fd_in)
    );
    // Toggle detect: a status bit moved between two reads
    function automatic logic toggled(input logic [7:0] a, input logic [7:0] b, input int bit_i);
        toggled = a[bit_i] ^ b[bit_i];
    endfunction
    // ****************************************************
    // Registers
    // ****************************************************
    fwsr_state_type state_r;
    fwsr_op_type    op_r;
    logic [17:0]    addr_r;
    logic [7:0]     data_r;
    logic [7:0]     rd1_r;
    logic [7:0]     rd2_r;
    logic           busy_r;
    logic           done_r;
    logic           fail_r;
    logic           win_r;
    logic           rst_busy_r;
    logic [15:0]    rcnt_r;
    logic           go;
    logic           req_r;
    logic           wr_r;
    assign go = psel && penable && pwrite && pready == 1'b0 &&
                paddr == `FWSR_CTRL_OFF && pwdata[`FWSR_CTRL_GO] && !busy_r;
    assign bus.req   = req_r;
    assign bus.wr    = wr_r;
    assign bus.addr  = addr_r;
    assign bus.wdata = data_r;
    // APB: one wait state, access answered on second access cycle
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
            addr_r  <= 18'h0_0000;
            data_r  <= 8'h00;
        end else begin
            pready  <= psel && penable && !pready;
            pslverr <= 1'b0;
            if (psel && penable && !pready) begin
                pslverr <= paddr > `FWSR_RDAT_OFF || paddr[1:0] != 2'b00;
                if (pwrite && !busy_r && paddr == `FWSR_ADDR_OFF)
                    addr_r <= pwdata[17:0];  // [R4]
                if (pwrite && !busy_r && paddr == `FWSR_DATA_OFF)
                    data_r <= pwdata[7:0];
                case (paddr)
                    `FWSR_ADDR_OFF: prdata <= {14'h0000, addr_r};
                    `FWSR_DATA_OFF: prdata <= {24'h00_0000, data_r};
                    `FWSR_STAT_OFF: prdata <= {27'h000_0000, rst_busy_r, win_r,
                                               fail_r, done_r, busy_r};
                    `FWSR_RDAT_OFF: prdata <= {16'h0000, rd1_r, rd2_r};
                    default:        prdata <= 32'h0000_0000;
                endcase
            end
        end
    end
    // Sequencer: one read, write, status poll or reset per order
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_r    <= FWSR_IDLE;  // [R22]
            op_r       <= FWSR_OP_READ;
            busy_r     <= 1'b0;
            done_r     <= 1'b0;
            fail_r     <= 1'b0;
            win_r      <= 1'b0;
            rst_busy_r <= 1'b0;
            rd1_r      <= 8'h00;
            rd2_r      <= 8'h00;
            rcnt_r     <= 16'h0000;
            req_r      <= 1'b0;
            wr_r       <= 1'b0;
            frst_n     <= 1'b1;
        end else begin
            case (state_r)
                FWSR_IDLE: begin
                    if (go) begin
                        op_r   <= fwsr_op_type'(pwdata[`FWSR_CTRL_OP_LO +: 3]);
                        busy_r <= 1'b1;
                        done_r <= 1'b0;
                        if (fwsr_op_type'(pwdata[`FWSR_CTRL_OP_LO +: 3]) == FWSR_OP_RESET) begin
                            frst_n     <= 1'b0;  // [R19] [R20]
                            rst_busy_r <= 1'b1;
                            fail_r     <= 1'b0;
                            rcnt_r     <= 16'(RST_LOW_CYC);
                            state_r    <= FWSR_RST_LOW;
                        end else if (fwsr_op_type'(pwdata[`FWSR_CTRL_OP_LO +: 3]) == FWSR_OP_WRITE) begin
                            req_r   <= 1'b1;
                            wr_r    <= 1'b1;
                            state_r <= FWSR_WR;
                        end else begin
                            req_r   <= 1'b1;
                            wr_r    <= 1'b0;
                            state_r <= FWSR_RD1;
                        end
                    end
                end
                FWSR_WR: begin
                    req_r <= 1'b0;
                    if (bus.ack) begin
                        busy_r  <= 1'b0;
                        done_r  <= 1'b1;
                        state_r <= FWSR_IDLE;
                    end
                end
                FWSR_RD1: begin
                    req_r <= 1'b0;
                    if (bus.ack) begin
                        rd1_r <= bus.rdata;
                        if (op_r == FWSR_OP_READ) begin
                            busy_r  <= 1'b0;
                            done_r  <= 1'b1;
                            state_r <= FWSR_IDLE;
                        end else begin
                            req_r   <= 1'b1;  // Second read to compare [R5] [R6]
                            state_r <= FWSR_RD2;
                        end
                    end
                end
                FWSR_RD2: begin
                    req_r <= 1'b0;
                    if (bus.ack) begin
                        rd2_r   <= bus.rdata;
                        state_r <= FWSR_EVAL;
                    end
                end
                FWSR_EVAL: begin
                    busy_r  <= 1'b0;
                    state_r <= FWSR_IDLE;
                    // Window bit seen while operation runs [R13] [R14] [R15]
                    win_r   <= rd2_r[`FWSR_WIN_BIT];
                    if (op_r == FWSR_OP_POLL) begin
                        // Poll matches expected bit 7: finished [R1] [R3] [R2]
                        if (rd2_r[`FWSR_POLL_BIT] == data_r[`FWSR_POLL_BIT])
                            done_r <= 1'b1;
                        else if (rd2_r[`FWSR_FAIL_BIT])
                            fail_r <= 1'b1;  // [R10] [R11] [R12]
                    end else begin
                        // Busy bit steady means finished or suspended [R7] [R8] [R9] [R18]
                        if (!toggled(rd1_r, rd2_r, `FWSR_TOG_BIT))
                            done_r <= 1'b1;
                        else if (rd2_r[`FWSR_FAIL_BIT])
                            fail_r <= 1'b1;  // [R10] [R17] [R16]
                    end
                end
                FWSR_RST_LOW: begin
                    if (rcnt_r == 16'h0001) begin
                        frst_n  <= 1'b1;
                        rcnt_r  <= 16'(RST_RDY_CYC - RST_LOW_CYC);
                        state_r <= FWSR_RST_WAIT;
                    end else begin
                        rcnt_r <= rcnt_r - 16'h0001;  // [R21] no access while low
                    end
                end
                FWSR_RST_WAIT: begin
                    if (rcnt_r <= 16'h0001) begin
                        rst_busy_r <= 1'b0;
                        busy_r     <= 1'b0;
                        done_r     <= 1'b1;
                        state_r    <= FWSR_IDLE;
                    end else begin
                        rcnt_r <= rcnt_r - 16'h0001;
                    end
                end
                default: state_r <= FWSR_IDLE;
            endcase
        end
    end
    // ****************************************************
    // Assertions
    // ****************************************************
    logic [15:0] low_cnt_r;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) low_cnt_r <= 16'h0000;
        else if (!frst_n) low_cnt_r <= low_cnt_r + 16'h0001;
        else low_cnt_r <= 16'h0000;
    end
    a_reset_low_len: assert property (@(posedge mclk) disable iff (!reset_n) // [R19]
        $rose(frst_n) |-> $past(low_cnt_r) >= 16'(RST_LOW_CYC - 1))
        else $error("flash reset pulse too short");
    // Age of the reset-in-progress flag, for the ready time check
    logic [15:0] rst_age_r;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) rst_age_r <= 16'h0000;
        else if (rst_busy_r) rst_age_r <= rst_age_r + 16'h0001;
        else rst_age_r <= 16'h0000;
    end
    a_reset_ready: assert property (@(posedge mclk) disable iff (!reset_n) // [R20]
        $fell(rst_busy_r) |-> $past(rst_age_r) >= 16'(RST_RDY_CYC - 1))
        else $error("flash ready reported before reset time");
    a_no_strobe_rst: assert property (@(posedge mclk) disable iff (!reset_n) // [R21]
        !frst_n |-> ce_n && oe_n && we_n && fd_oe_n)
        else $error("strobe during flash reset");
    a_rst_busy_hold: assert property (@(posedge mclk) disable iff (!reset_n) // [R20]
        $fell(frst_n) |-> rst_busy_r [*8])
        else $error("reset ready too early");
    a_poll_done: assert property (@(posedge mclk) disable iff (!reset_n) // [R1]
        state_r == FWSR_EVAL && op_r == FWSR_OP_POLL &&
        rd2_r[`FWSR_POLL_BIT] == data_r[`FWSR_POLL_BIT] |=> done_r && !busy_r)
        else $error("poll match not reported done");
    a_poll_wait: assert property (@(posedge mclk) disable iff (!reset_n) // [R3]
        state_r == FWSR_EVAL && op_r == FWSR_OP_POLL &&
        rd2_r[`FWSR_POLL_BIT] != data_r[`FWSR_POLL_BIT] |=> !done_r)
        else $error("poll mismatch reported done");
    a_toggle_busy: assert property (@(posedge mclk) disable iff (!reset_n) // [R6]
        state_r == FWSR_EVAL && op_r == FWSR_OP_TOGGLE &&
        toggled(rd1_r, rd2_r, `FWSR_TOG_BIT) |=> !done_r)
        else $error("toggling bit reported done");
    a_fail_flag: assert property (@(posedge mclk) disable iff (!reset_n) // [R10]
        state_r == FWSR_EVAL && op_r == FWSR_OP_TOGGLE && rd2_r[`FWSR_FAIL_BIT] &&
        toggled(rd1_r, rd2_r, `FWSR_TOG_BIT) |=> fail_r)
        else $error("fail bit not captured");
    a_window_copy: assert property (@(posedge mclk) disable iff (!reset_n) // [R13]
        state_r == FWSR_EVAL |=> win_r == $past(rd2_r[`FWSR_WIN_BIT]))
        else $error("window bit not captured");
    sequence s_rd_pair;
        state_r == FWSR_RD1 && bus.ack ##1 state_r == FWSR_RD2;
    endsequence
    a_two_reads: assert property (@(posedge mclk) disable iff (!reset_n) // [R5]
        s_rd_pair |-> ##[1:300] state_r == FWSR_EVAL)
        else $error("second read missing");
endmodule

// File: verification/fwsr_flash_model.sv
// Behavioural byte-wide flash showing write status flags on its data bits.
// Assumes strobes move on mclk edges; unlock cycles not modelled; location PROT_IDX is protected from program and erase.
`timescale 1ns/10ps
module fwsr_flash_model #(
    parameter int PROG_CYC  = 200,
    parameter int WIN_CYC   = 150,
    parameter int ERASE_CYC = 800,
    parameter int FAIL_CYC  = 300,
    parameter int PROT_IDX  = 15
) (
    // Timing clock
    input  wire logic        mclk,
    // Flash pins
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic        frst_n,
    input  wire logic [17:0] fa,
    input  wire logic [7:0]  fd_out,
    input  wire logic        fd_oe_n,
    output logic      [7:0]  fd_in
);
    logic [7:0] mem [16];
    logic [7:0] pdata = 8'h00;
    logic [7:0] last  = 8'h00;
    logic [7:0] fd_q  = 8'h00;
    logic [3:0] fa_q  = 4'h0;
    logic [3:0] pidx  = 4'h0;
    logic       busy  = 1'b0;
    logic       ers   = 1'b0;
    logic       armed = 1'b0;
    logic       lock  = 1'b0;
    logic       tog   = 1'b0;
    logic       estog = 1'b0;
    logic       fail  = 1'b0;
    logic       we_q  = 1'b1;
    logic       ce_q  = 1'b1;
    logic       oe_q  = 1'b1;
    logic       win;
    int         cnt   = 0;
    // Erased contents at power-up, read mode
    initial foreach (mem[i]) mem[i] = 8'hFF;
    assign win = cnt >= WIN_CYC;
    // Algorithm timing, command capture and reset abort
    always @(posedge mclk or negedge frst_n) begin
        if (!frst_n) begin
            busy  <= 1'b0;
            armed <= 1'b0;
            fail  <= 1'b0;
            cnt   <= 0;
        end else begin
            we_q <= we_n;
            ce_q <= ce_n;
            oe_q <= oe_n;
            fa_q <= fa[3:0];
            fd_q <= fd_out;
            cnt  <= cnt + 1;
            if (!ce_n && !oe_n) begin
                last <= fd_in;
            end
            if (oe_n && !oe_q && !ce_q && busy) begin
                tog   <= ~tog;
                estog <= ~estog;
            end
            if (busy && lock && cnt >= FAIL_CYC) begin
                fail <= 1'b1;
            end
            if (busy && !lock && cnt >= (ers ? ERASE_CYC : PROG_CYC)) begin
                busy <= 1'b0;
                if (ers) begin
                    for (int i = 0; i < 16; i++) if (i != PROT_IDX) mem[i] <= 8'hFF;
                end else begin
                    if (pidx != 4'(PROT_IDX)) mem[pidx] <= pdata;
                end
            end
            // Writes are ignored while an algorithm runs
            if (we_n && !we_q && !ce_q && !busy) begin
                armed <= fd_q == 8'hA0;
                cnt   <= 0;
                if (armed) begin
                    busy  <= 1'b1;
                    ers   <= 1'b0;
                    pdata <= fd_q;
                    pidx  <= fa_q;
                    lock  <= |(fd_q & ~mem[fa_q]);
                end else if (fd_q == 8'h30) begin
                    busy <= 1'b1;
                    ers  <= 1'b1;
                    lock <= 1'b0;
                end
            end
        end
    end
    // Read data, status byte, or a released bus
    always_comb begin
        if (!frst_n || ce_n || oe_n) begin
            fd_in = ~last;
        end else if (!busy) begin
            fd_in = mem[fa[3:0]];
        end else if (ers) begin
            fd_in = {1'b0, tog, fail, 1'b0, win, estog, 2'b00};
        end else begin
            fd_in = {~pdata[7], tog, fail, 5'h00};
        end
    end
endmodule

// File: verification/testbench.sv
// Self-checking bench for the flash status poll controller.
// Assumes the behavioural flash model on the pins, APB driven here.
`timescale 1ns/10ps
`include "fwsr_params.svh"
module testbench
    import fwsr_pkg::*;
();
    logic        mclk    = 1'b0;
    logic        reset_n = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [31:0] prdata, q, stat, rdat;
    logic        pready, pslverr, err, ce_n, oe_n, we_n, frst_n, fd_oe_n;
    logic [17:0] fa;
    logic [7:0]  fd_out, fd_in;
    int          failures = 0;
    int          n_checks = 0;
    int          rst_low  = 0;
    fwsr_ctrl #(.RST_RDY_CYC(60), .STROBE_CYC(8)) u_fwsr_ctrl (.mclk, .reset_n, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ce_n, .oe_n,
        .we_n, .frst_n, .fa, .fd_out, .fd_oe_n, .fd_in);
    fwsr_flash_model u_fwsr_flash_model (.mclk, .ce_n, .oe_n, .we_n, .frst_n, .fa,
        .fd_out, .fd_oe_n, .fd_in);
    // Clock and flash reset pulse width counter
    initial forever #5 mclk = ~mclk;
    always @(posedge mclk) if (frst_n === 1'b0) rst_low++;
    // ****************************************************
    // Checking and bus tasks
    // ****************************************************
    task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic chk1(input string w, input logic e, input logic g);
        chk(w, {31'h0000_0000, e}, {31'h0000_0000, g});
    endtask
    task automatic summarize();
        if (failures == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            chk1("apb pready", 1'b1, 1'b0);
            summarize();
        end
        q   = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic start_op(input fwsr_op_type o, input logic [17:0] a, input logic [7:0] d);
        apb(1'b1, `FWSR_ADDR_OFF, {14'h0000, a});
        apb(1'b1, `FWSR_DATA_OFF, {24'h00_0000, d});
        apb(1'b1, `FWSR_CTRL_OFF, {28'h000_0000, o, 1'b1});
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            apb(1'b0, `FWSR_STAT_OFF, 32'h0000_0000);
            n++;
        end while (q[0] !== 1'b0 && n < 200);
        if (q[0] !== 1'b0) begin
            chk1("stat busy", 1'b0, 1'b1);
            summarize();
        end
        stat = q;
        apb(1'b0, `FWSR_RDAT_OFF, 32'h0000_0000);
        rdat = q;
    endtask
    task automatic op(input fwsr_op_type o, input logic [17:0] a, input logic [7:0] d);
        start_op(o, a, d);
        wait_idle();
    endtask
    task automatic op_until(input fwsr_op_type o, input logic [17:0] a, input logic [7:0] d,
                            input int b);
        int n;
        n = 0;
        do begin
            op(o, a, d);
            n++;
        end while (stat[b] !== 1'b1 && n < 40);
        if (stat[b] !== 1'b1) begin
            chk1("status flag", 1'b1, 1'b0);
            summarize();
        end
    endtask
    // ****************************************************
    // Scenarios
    // ****************************************************
    task automatic t_regs();
        apb(1'b0, `FWSR_STAT_OFF, 32'h0000_0000);
        chk("stat after reset", 32'h0000_0000, q);
        apb(1'b0, 12'h014, 32'h0000_0000);
        chk1("unmapped pslverr", 1'b1, err);
    endtask
    task automatic t_program();
        op(FWSR_OP_WRITE, 18'h0_0003, 8'hA0);
        op(FWSR_OP_WRITE, 18'h0_0003, 8'h5A);
        op(FWSR_OP_POLL, 18'h0_0003, 8'h5A);
        chk1("poll done early", 1'b0, stat[`FWSR_STAT_DONE]);
        chk1("poll bit busy", 1'b1, rdat[7]);
        op(FWSR_OP_TOGGLE, 18'h0_0011, 8'h00);
        chk1("busy bit toggles", 1'b1, rdat[14] ^ rdat[6]);
        op_until(FWSR_OP_POLL, 18'h0_0003, 8'h5A, `FWSR_STAT_DONE);
        op(FWSR_OP_TOGGLE, 18'h0_0003, 8'h00);
        chk1("toggle stops", 1'b1, stat[`FWSR_STAT_DONE]);
        op(FWSR_OP_READ, 18'h0_0003, 8'h00);
        chk("programmed byte", 32'h0000_005A, {24'h00_0000, rdat[15:8]});
    endtask
    task automatic t_lock();
        op(FWSR_OP_WRITE, 18'h0_0003, 8'hA0);
        op(FWSR_OP_WRITE, 18'h0_0003, 8'hFF);
        op_until(FWSR_OP_POLL, 18'h0_0003, 8'hFF, `FWSR_STAT_FAIL);
        chk1("lock never done", 1'b0, stat[`FWSR_STAT_DONE]);
        op(FWSR_OP_TOGGLE, 18'h0_0003, 8'h00);
        chk1("toggle with fail", 1'b1, rdat[14] ^ rdat[6]);
        chk1("fail bit read", 1'b1, rdat[5]);
        rst_low = 0;
        start_op(FWSR_OP_RESET, 18'h0_0000, 8'h00);
        apb(1'b0, `FWSR_STAT_OFF, 32'h0000_0000);
        chk1("reset in progress", 1'b1, q[`FWSR_STAT_RST]);
        wait_idle();
        chk1("reset pulse width", 1'b1, rst_low >= `FWSR_RST_LOW_CYC);
        chk1("fail cleared", 1'b0, stat[`FWSR_STAT_FAIL]);
        op(FWSR_OP_TOGGLE, 18'h0_0003, 8'h00);
        chk1("read mode after reset", 1'b1, stat[`FWSR_STAT_DONE]);
    endtask
    task automatic t_erase();
        op(FWSR_OP_WRITE, 18'h0_0005, 8'h30);
        op(FWSR_OP_TOGGLE, 18'h0_0005, 8'h00);
        chk1("window still open", 1'b0, rdat[3]);
        chk1("erase poll bit", 1'b0, rdat[7]);
        chk1("erase sector toggle", 1'b1, rdat[10] ^ rdat[2]);
        chk1("busy in window", 1'b1, rdat[14] ^ rdat[6]);
        op_until(FWSR_OP_TOGGLE, 18'h0_0005, 8'h00, `FWSR_STAT_WIN);
        op_until(FWSR_OP_POLL, 18'h0_0005, 8'h80, `FWSR_STAT_DONE);
        op(FWSR_OP_READ, 18'h0_0003, 8'h00);
        chk("erased byte", 32'h0000_00FF, {24'h00_0000, rdat[15:8]});
        op(FWSR_OP_WRITE, 18'h0_000F, 8'hA0);
        op(FWSR_OP_WRITE, 18'h0_000F, 8'h00);
        op_until(FWSR_OP_TOGGLE, 18'h0_000F, 8'h00, `FWSR_STAT_DONE);
        op(FWSR_OP_READ, 18'h0_000F, 8'h00);
        chk("protected byte", 32'h0000_00FF, {24'h00_0000, rdat[15:8]});
    endtask
    // Main sequence
    initial begin
        repeat (3) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        t_regs();
        t_program();
        t_lock();
        t_erase();
        summarize();
    end
endmodule
